//--- include/ddcd_cfg.svh
`ifndef DDCD_CFG_SVH
`define DDCD_CFG_SVH

// Serial word layout
`define DDCD_FRAME_BITS  5'h10
`define DDCD_CMD_LSB     12
`define DDCD_PD_BIT      12
`define DDCD_SEL_LSB     14
`define DDCD_IMP_LSB     10

// Normal-mode command codes
`define DDCD_CMD_STORE_A 4'h0
`define DDCD_CMD_STORE_B 4'h2
`define DDCD_CMD_UPD_A   4'h4
`define DDCD_CMD_UPD_AXB 4'h6
`define DDCD_CMD_UPD_B   4'h8
`define DDCD_CMD_UPD_BXA 4'hA
`define DDCD_CMD_UPD_ALL 4'hC
`define DDCD_CMD_XFER    4'hE

// Power-down channel selects
`define DDCD_SEL_A       2'h1
`define DDCD_SEL_B       2'h2

// Reset values
`define DDCD_OUT_RST     12'h000
`define DDCD_TAP_MID     12'h800

// Register byte offsets
`define DDCD_ADDR_CTRL   8'h00
`define DDCD_ADDR_STAT   8'h04
`define DDCD_ADDR_CHA    8'h08
`define DDCD_ADDR_CHB    8'h0C

// Field positions
`define DDCD_CTRL_CHAIN  0
`define DDCD_ST_PD_A     0
`define DDCD_ST_IMP_A    1
`define DDCD_ST_PD_B     3
`define DDCD_ST_IMP_B    4
`define DDCD_ST_BUSY     8
`define DDCD_CH_OUT      0
`define DDCD_CH_STAGE    16

`endif

//--- include/ddcd_pkg.sv
package ddcd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_FRAME = 3'h2,
        ST_DONE  = 3'h4
    } ddcd_state_type;

    typedef enum logic [1:0] {
        IMP_FLOAT = 2'h0,
        IMP_1K    = 2'h1,
        IMP_100K  = 2'h2
    } ddcd_imp_type;

endpackage

//--- rtl/ddcd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ddcd_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [2:0] RST_VAL = 3'h0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // Two stages; only q is read downstream
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL[WIDTH-1:0];
            q      <= RST_VAL[WIDTH-1:0];
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

//--- rtl/ddcd_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddcd_cfg.svh"

module ddcd_shift (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic        shift,
    input  wire logic        din,
    input  wire logic        chain,
    output var  logic [15:0] word,
    output wire logic        full,
    output var  logic        out_bit
);

    logic [4:0] cnt_r;

    // Frame start restarts the count, even with a bit in the same cycle
    wire [4:0] cnt_base = start ? 5'h00 : cnt_r;
    wire       at_top   = (cnt_base == `DDCD_FRAME_BITS);
    // Plain mode keeps the first word; chained mode keeps the last
    wire       take     = shift && (chain || !at_top);
    wire [4:0] cnt_nxt  = (take && !at_top) ? 5'(cnt_base + 5'h01) : cnt_base;

    assign full = (cnt_r == `DDCD_FRAME_BITS);

    // Bit leaving the top appears 16 falls after it entered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word    <= 16'h0000;
            cnt_r   <= 5'h00;
            out_bit <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            if (take) begin
                word    <= {word[14:0], din};
                out_bit <= word[15];
            end
        end
    end

endmodule

`default_nettype wire

//--- rtl/ddcd_top.sv
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ddcd_cfg.svh"

// Functional notes
// RQ1: Store commands load one staging register only
// RQ2: Code 0100 loads staging and output A
// RQ3: Code 0110 loads A, copies B staging
// RQ4: Code 1000 loads staging and output B
// RQ5: Code 1010 loads B, copies A staging
// RQ6: Code 1100 loads both channels fully
// RQ7: Code 1110 transfers both staging to outputs
// RQ8: Power-down impedance: float, 1k, 100k
// RQ9: Power-down target from top two bits
// RQ10: Output code maps to tap 0..4095
// RQ11: Each channel keeps own power-down impedance
// RQ12: Reset clears registers, outputs at midscale
// RQ13: Clear pin resets everything immediately; chain_r and the other bus-side registers keep their values
// RQ14: After clear, act on next strobe rise
// RQ15: Sixteen bits, MSB first, falling clock
// RQ16: Short frame causes no register change
// RQ17: Chained output delays input sixteen clocks
// RQ18: Clear holds output registers at zero
// RQ19: Normal update wakes a powered-down channel
// RQ20: Tap equals code with MSB inverted

module ddcd_top (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  sclk_pin,
    input  wire logic                  sync_n_pin,
    input  wire logic                  serial_in,
    input  wire logic                  async_clear_n,
    output var  logic                  serial_out,
    output var  logic                  serial_out_oe,
    output var  logic [11:0]           tap_a,
    output var  logic [11:0]           tap_b,
    output var  logic                  pd_a,
    output var  logic                  pd_b,
    output var  ddcd_pkg::ddcd_imp_type imp_a,
    output var  ddcd_pkg::ddcd_imp_type imp_b,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output var  logic                  hreadyout,
    output var  logic                  hresp,
    output var  logic [31:0]           hrdata
);
    import ddcd_pkg::*;

    // Twos-complement code to string tap
    function automatic logic [11:0] to_tap(input logic [11:0] code);
        to_tap = {~code[11], code[10:0]}; // RQ10 RQ20
    endfunction

    // Two-bit field to output impedance
    function automatic ddcd_imp_type imp_dec(input logic [1:0] f);
        case (f)
            2'h1:    imp_dec = IMP_1K;
            2'h2:    imp_dec = IMP_100K;
            default: imp_dec = IMP_FLOAT; // RQ8
        endcase
    endfunction

    // Channel readback word
    function automatic logic [31:0] ch_word(input logic [11:0] stg,
                                            input logic [11:0] outr);
        ch_word = 32'h0;
        ch_word[`DDCD_CH_OUT +: 12]   = outr;
        ch_word[`DDCD_CH_STAGE +: 12] = stg;
    endfunction

    logic           lrst_meta_r;
    logic           lrst_n;
    logic [2:0]     pin_q;
    logic           sclk_d_r;
    logic           sync_d_r;
    ddcd_state_type state_r;
    ddcd_state_type state_nxt;
    logic [15:0]    word;
    logic           full;
    logic           sh_out;
    logic [11:0]    stage_a_r;
    logic [11:0]    stage_b_r;
    logic [11:0]    out_a_r;
    logic [11:0]    out_b_r;
    logic           chain_r;
    logic           wr_pend_r;
    logic [7:0]     addr_r;
    logic [31:0]    stat_w;

    // Clear pin and reset share one asynchronous path; release is synced
    // so a clear pulse of any width still leaves cleanly
    wire clr_any_n = rstn & async_clear_n;

    always_ff @(posedge core_clk or negedge clr_any_n) begin
        if (!clr_any_n) begin
            lrst_meta_r <= 1'b0; // RQ13
            lrst_n      <= 1'b0;
        end else if (ce) begin
            lrst_meta_r <= 1'b1;
            lrst_n      <= lrst_meta_r;
        end
    end

    // Link pins cross in from the host's clock
    ddcd_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h2)
    ) u_pin_sync (
        .clk   (core_clk),
        .rst_n (lrst_n),
        .ce    (ce),
        .d     ({sclk_pin, sync_n_pin, serial_in}),
        .q     (pin_q)
    );

    wire sclk_s = pin_q[2];
    wire sync_s = pin_q[1];
    wire serial_in_s = pin_q[0];

    // Edges of the sampled link clock and strobe
    wire sclk_fall = sclk_d_r & ~sclk_s;
    wire sync_fall = sync_d_r & ~sync_s;
    wire sync_rise = ~sync_d_r & sync_s;
    wire shift_en  = sclk_fall & ~sync_s; // RQ15

    always_ff @(posedge core_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            sclk_d_r <= 1'b0;
            sync_d_r <= 1'b1;
        end else if (ce) begin
            sclk_d_r <= sclk_s;
            sync_d_r <= sync_s;
        end
    end

    ddcd_shift u_shift (
        .clk     (core_clk),
        .rst_n   (lrst_n),
        .ce      (ce),
        .start   (sync_fall),
        .shift   (shift_en),
        .din     (serial_in_s),
        .chain   (chain_r),
        .word    (word),
        .full    (full),
        .out_bit (sh_out)
    );

    // Frame sequencing; a clear mid-frame leaves a short count
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (sync_fall) state_nxt = ST_FRAME;
            ST_FRAME: if (sync_rise) state_nxt = ST_DONE; // RQ14
            ST_DONE:  state_nxt = sync_fall ? ST_FRAME : ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Checked a cycle after the rise so a late last bit still counts
    wire        apply_go = (state_r == ST_DONE) && full; // RQ16
    wire [3:0]  cmd      = word[`DDCD_CMD_LSB +: 4];
    wire [11:0] data     = word[11:0];
    wire [1:0]  sel      = word[`DDCD_SEL_LSB +: 2];
    wire        is_pd    = word[`DDCD_PD_BIT];

    // Normal-mode decode
    wire st_a = !is_pd && (cmd == `DDCD_CMD_STORE_A || cmd == `DDCD_CMD_UPD_A
        || cmd == `DDCD_CMD_UPD_AXB || cmd == `DDCD_CMD_UPD_ALL); // RQ1
    wire st_b = !is_pd && (cmd == `DDCD_CMD_STORE_B || cmd == `DDCD_CMD_UPD_B
        || cmd == `DDCD_CMD_UPD_BXA || cmd == `DDCD_CMD_UPD_ALL); // RQ1
    wire oa_d = cmd == `DDCD_CMD_UPD_A || cmd == `DDCD_CMD_UPD_AXB
        || cmd == `DDCD_CMD_UPD_ALL; // RQ2 RQ3 RQ6
    wire ob_d = cmd == `DDCD_CMD_UPD_B || cmd == `DDCD_CMD_UPD_BXA
        || cmd == `DDCD_CMD_UPD_ALL; // RQ4 RQ5 RQ6
    wire oa_s = cmd == `DDCD_CMD_UPD_BXA || cmd == `DDCD_CMD_XFER; // RQ5 RQ7
    wire ob_s = cmd == `DDCD_CMD_UPD_AXB || cmd == `DDCD_CMD_XFER; // RQ3 RQ7

    // Power-down decode ignores channel bit and low data
    wire pd_hit_a = is_pd && (sel != `DDCD_SEL_B); // RQ9
    wire pd_hit_b = is_pd && (sel != `DDCD_SEL_A); // RQ9
    wire wake_a   = !is_pd && (oa_d || oa_s);
    wire wake_b   = !is_pd && (ob_d || ob_s);
    wire ddcd_imp_type imp_new = imp_dec(word[`DDCD_IMP_LSB +: 2]);

    // Next values of channel state
    wire [11:0] stage_a_nxt = (apply_go && st_a) ? data : stage_a_r;
    wire [11:0] stage_b_nxt = (apply_go && st_b) ? data : stage_b_r;
    wire [11:0] out_a_nxt = !(apply_go && !is_pd) ? out_a_r
        : oa_d ? data : oa_s ? stage_a_r : out_a_r;
    wire [11:0] out_b_nxt = !(apply_go && !is_pd) ? out_b_r
        : ob_d ? data : ob_s ? stage_b_r : out_b_r;

    // Old staging is copied, so a copy sees the value before this word
    always_ff @(posedge core_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            stage_a_r <= `DDCD_OUT_RST; // RQ12
            stage_b_r <= `DDCD_OUT_RST;
            out_a_r   <= `DDCD_OUT_RST; // RQ18
            out_b_r   <= `DDCD_OUT_RST;
            tap_a     <= `DDCD_TAP_MID;
            tap_b     <= `DDCD_TAP_MID;
        end else if (ce) begin
            stage_a_r <= stage_a_nxt;
            stage_b_r <= stage_b_nxt;
            out_a_r   <= out_a_nxt;
            out_b_r   <= out_b_nxt;
            tap_a     <= to_tap(out_a_nxt); // RQ10
            tap_b     <= to_tap(out_b_nxt);
        end
    end

    // Per-channel power state; a normal update wakes the channel
    always_ff @(posedge core_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            pd_a  <= 1'b0;
            pd_b  <= 1'b0;
            imp_a <= IMP_FLOAT;
            imp_b <= IMP_FLOAT;
        end else if (ce && apply_go) begin
            if (pd_hit_a) begin
                pd_a  <= 1'b1; // RQ11
                imp_a <= imp_new;
            end else if (wake_a) begin
                pd_a <= 1'b0; // RQ19
            end
            if (pd_hit_b) begin
                pd_b  <= 1'b1; // RQ11
                imp_b <= imp_new;
            end else if (wake_b) begin
                pd_b <= 1'b0; // RQ19
            end
        end
    end

    // Chained output is driven only inside a frame
    always_ff @(posedge core_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (ce) begin
            serial_out    <= sh_out; // RQ17
            serial_out_oe <= chain_r & ~sync_s; // RQ17
        end
    end

    // Bus address phase; read data is fetched here, so no wait states
    wire       bus_take = hsel & hready & htrans[1] & ce;
    wire [7:0] bus_addr = haddr[7:0];

    always_comb begin
        stat_w = 32'h0;
        stat_w[`DDCD_ST_PD_A]      = pd_a;
        stat_w[`DDCD_ST_IMP_A +: 2] = imp_a;
        stat_w[`DDCD_ST_PD_B]      = pd_b;
        stat_w[`DDCD_ST_IMP_B +: 2] = imp_b;
        stat_w[`DDCD_ST_BUSY]      = (state_r != ST_IDLE);
    end

    wire [31:0] rd_mux =
        (bus_addr == `DDCD_ADDR_CTRL) ? {31'h0, chain_r} :
        (bus_addr == `DDCD_ADDR_STAT) ? stat_w :
        (bus_addr == `DDCD_ADDR_CHA)  ? ch_word(stage_a_r, out_a_r) :
        (bus_addr == `DDCD_ADDR_CHB)  ? ch_word(stage_b_r, out_b_r) :
        32'h0;

    // Bus side keeps its own reset; the clear pin leaves it alone
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata    <= 32'h0;
            chain_r   <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (wr_pend_r && addr_r == `DDCD_ADDR_CTRL) begin
                chain_r <= hwdata[`DDCD_CTRL_CHAIN];
            end
            wr_pend_r <= bus_take & hwrite;
            if (bus_take) begin
                addr_r <= bus_addr;
                if (!hwrite) begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    // Checks

    a_store_a: assert property ( // RQ1
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && !is_pd && cmd == `DDCD_CMD_STORE_A
        |=> stage_a_r == $past(data) && $stable(out_a_r) && $stable(out_b_r))
        else $error("store A changed an output register");

    a_upd_a: assert property ( // RQ2
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_A
        |=> out_a_r == $past(data) && stage_a_r == $past(data)
            && $stable(out_b_r))
        else $error("update A wrong");

    a_upd_a_cpy: assert property ( // RQ3
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_AXB
        |=> out_a_r == $past(data) && out_b_r == $past(stage_b_r))
        else $error("update A with B copy wrong");

    a_upd_b: assert property ( // RQ4
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_B
        |=> out_b_r == $past(data) && stage_b_r == $past(data)
            && $stable(out_a_r))
        else $error("update B wrong");

    a_upd_b_cpy: assert property ( // RQ5
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_BXA
        |=> out_b_r == $past(data) && out_a_r == $past(stage_a_r))
        else $error("update B with A copy wrong");

    a_upd_all: assert property ( // RQ6
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_ALL
        |=> out_a_r == $past(data) && out_b_r == $past(data)
            && tap_b == to_tap($past(data)))
        else $error("update all wrong");

    a_xfer_all: assert property ( // RQ7
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_XFER
        |=> out_a_r == $past(stage_a_r) && out_b_r == $past(stage_b_r)
            && $stable(stage_a_r))
        else $error("transfer all wrong");

    a_pd_apply: assert property ( // RQ8
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && is_pd && sel == `DDCD_SEL_B
        |=> pd_b && imp_b == imp_dec($past(word[11:10])) && $stable(pd_a)
            && $stable(out_b_r))
        else $error("power-down B decode wrong");

    a_short_frame: assert property ( // RQ16
        @(posedge core_clk) disable iff (!lrst_n)
        ce && state_r == ST_FRAME && sync_rise && !full && !shift_en
        |=> ##1 $stable(out_a_r) && $stable(stage_b_r) && $stable(pd_a))
        else $error("short frame changed state");

    a_clear_mid: assert property ( // RQ18
        @(posedge core_clk) disable iff (!rstn)
        !lrst_n |-> out_a_r == `DDCD_OUT_RST && tap_a == `DDCD_TAP_MID)
        else $error("clear did not force midscale");

    a_sdo_hiz: assert property ( // RQ17
        @(posedge core_clk) disable iff (!lrst_n)
        ce && (!chain_r || sync_s) |=> !serial_out_oe)
        else $error("serial output driven outside chain frame");

    a_wake: assert property ( // RQ19
        @(posedge core_clk) disable iff (!lrst_n)
        ce && apply_go && cmd == `DDCD_CMD_UPD_A |=> !pd_a)
        else $error("update did not wake channel A");

endmodule

`default_nettype wire

//--- testbench/ddcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Serial host master; link clock idles high and stands still between frames
module ddcd_host_model (
    output var logic sclk,
    output var logic sync_n,
    output var logic sdata
);
    initial begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        sdata  = 1'b0;
    end

    // Sends the first n bits of w, top bit first; open_end keeps the frame going
    task automatic send(input logic [15:0] w, input int n, input logic open_end);
        int i;
        if (sync_n) begin
            // Half-ns offset keeps every pin change off the rising core clock edges
            #0.5;
            sync_n = 1'b0;
            #10;
        end
        for (i = 0; i < n; i++) begin
            sdata = w[15-i];
            #12;
            sclk = 1'b0;
            #24;
            sclk = 1'b1;
            #12;
        end
        // Released line shows the inverse, so a stale bit cannot pass
        if (!open_end) begin
            #5;
            sync_n = 1'b1;
            sdata  = ~sdata;
            #60;
        end
    endtask
endmodule

`default_nettype wire

//--- testbench/ddcd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ddcd_top_tb;
    import ddcd_pkg::*;

    logic                   core_clk;
    logic                   rstn;
    logic                   ce;
    logic                   async_clear_n;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    wire logic              sclk;
    wire logic              sync_n;
    wire logic              sdi;
    logic                   serial_out;
    logic                   serial_out_oe;
    logic [11:0]            tap_a;
    logic [11:0]            tap_b;
    logic                   pd_a;
    logic                   pd_b;
    ddcd_imp_type           imp_a;
    ddcd_imp_type           imp_b;
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    int                     failures;
    int                     tests_run;
    int                     cycles;
    logic [11:0]            sa, sb, oa, ob;
    logic                   pa, pb;
    logic [1:0]             ia, ib;

    ddcd_host_model i_host (.sclk(sclk), .sync_n(sync_n), .sdata(sdi));

    ddcd_top i_dut (
        .core_clk(core_clk), .rstn(rstn), .ce(ce), .sclk_pin(sclk), .sync_n_pin(sync_n),
        .serial_in(sdi), .async_clear_n(async_clear_n), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .tap_a(tap_a), .tap_b(tap_b), .pd_a(pd_a),
        .pd_b(pd_b), .imp_a(imp_a), .imp_b(imp_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly seven thousand cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single AHB-Lite transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic mreset();
        {sa, sb, oa, ob} = 48'h0;
        {pa, pb, ia, ib} = 6'h0;
    endtask

    // Expected effect of one applied word
    task automatic model(input logic [15:0] w);
        logic [11:0] d, pre_a, pre_b;
        d     = w[11:0];
        pre_a = sa;
        pre_b = sb;
        if (w[12]) begin
            // Impedance code 3 folds to floating
            if (w[15:14] != 2'h2) begin
                pa = 1'b1;
                ia = (w[11:10] == 2'h3) ? 2'h0 : w[11:10];
            end
            if (w[15:14] != 2'h1) begin
                pb = 1'b1;
                ib = (w[11:10] == 2'h3) ? 2'h0 : w[11:10];
            end
        end else begin
            case (w[15:13])
                3'h0: sa = d;
                3'h1: sb = d;
                3'h2: {sa, oa} = {d, d};
                3'h3: {sa, oa, ob} = {d, d, pre_b};
                3'h4: {sb, ob} = {d, d};
                3'h5: {sb, ob, oa} = {d, d, pre_a};
                3'h6: {sa, oa, sb, ob} = {d, d, d, d};
                default: {oa, ob} = {pre_a, pre_b};
            endcase
            if (w[15:13] inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7}) pa = 1'b0;
            if (w[15:13] inside {3'h3, 3'h4, 3'h5, 3'h6, 3'h7}) pb = 1'b0;
        end
    endtask

    task automatic check_all();
        logic [31:0] r;
        check(tap_a, {20'h0, oa ^ 12'h800});
        check(tap_b, {20'h0, ob ^ 12'h800});
        check(pd_a, pa);
        check(pd_b, pb);
        if (pa) check(imp_a, ia);
        if (pb) check(imp_b, ib);
        ahb(1'b0, 32'h08, 32'h0, r);
        check(r, {4'h0, sa, 4'h0, oa});
        ahb(1'b0, 32'h0C, 32'h0, r);
        check(r, {4'h0, sb, 4'h0, ob});
        ahb(1'b0, 32'h04, 32'h0, r);
        check({r[8], r[3], r[0]}, {1'b0, pb, pa});
        check(hresp, 1'b0);
    endtask

    task automatic frame(input logic [15:0] w);
        i_host.send(w, 16, 1'b0);
        model(w);
        check_all();
    endtask

    // Reset state, unmapped read, ignored write to a read-only place
    task automatic t_reset();
        logic [31:0] r;
        mreset();
        check_all();
        ahb(1'b0, 32'h10, 32'h0, r);
        check(r, 32'h0);
        ahb(1'b1, 32'h04, 32'hFFFFFFFF, r);
        check_all();
    endtask

    // Every normal command, with boundary codes first
    task automatic t_commands();
        int c;
        frame(16'h4800);
        frame(16'h87FF);
        for (c = 0; c < 8; c++) begin
            frame({c[2:0], 1'b0, 12'h1A5 ^ (12'h2C3 * c[11:0])});
        end
        frame(16'h0321);
        frame(16'hE000);
    endtask

    // A frame cut short leaves every register alone; so does one sent while frozen
    task automatic t_short();
        i_host.send(16'hC5A5, 10, 1'b0);
        check_all();
        i_host.send(16'h4123, 15, 1'b0);
        check_all();
        @(posedge core_clk);
        ce <= 1'b0;
        i_host.send(16'hC5A5, 16, 1'b0);
        @(posedge core_clk);
        ce <= 1'b1;
        check_all();
    endtask

    // Every target and impedance, then a wake-up
    task automatic t_power();
        int i;
        for (i = 0; i < 16; i++) begin
            frame({i[3:2], i[0], 1'b1, i[1:0], 10'h2B7});
        end
        frame(16'h4ABC);
        frame(16'h9C00);
        frame(16'hC456);
    endtask

    // Chained frame: second word pushes the first out on serial_out
    task automatic t_chain();
        logic [31:0] r;
        logic [15:0] w1;
        int k;
        w1 = 16'hA5C3;
        ahb(1'b1, 32'h00, 32'h1, r);
        ahb(1'b0, 32'h00, 32'h0, r);
        check(r, 32'h1);
        i_host.send(w1, 16, 1'b1);
        check(serial_out_oe, 1'b1);
        fork
            i_host.send(16'h6E21, 16, 1'b0);
            for (k = 0; k < 16; k++) begin
                @(negedge sclk);
                #30;
                check(serial_out, w1[15-k]);
            end
        join
        model(16'h6E21);
        check_all();
        check(serial_out_oe, 1'b0);
        ahb(1'b1, 32'h00, 32'h0, r);
    endtask

    // Clear acts at once, ignores frames, resumes only on a fresh frame
    task automatic t_clear();
        frame(16'h1800);
        @(posedge core_clk);
        async_clear_n <= 1'b0;
        #2;
        check(tap_a, 32'h800);
        check(tap_b, 32'h800);
        mreset();
        check_all();
        i_host.send(16'hC777, 16, 1'b0);
        check_all();
        fork
            i_host.send(16'hC123, 16, 1'b0);
            begin
                #300;
                @(posedge core_clk);
                async_clear_n <= 1'b1;
            end
        join
        check_all();
        frame(16'hC9AB);
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        async_clear_n = 1'b1;
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = 71'h0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        t_reset();
        t_commands();
        t_short();
        t_power();
        t_chain();
        t_clear();
        give_verdict();
    end
endmodule

`default_nettype wire
